// ### logic/fdchp_pkg.sv
package fdchp_pkg;
  // ****************************************
  // Register locations
  // ****************************************
  localparam logic [1:0] FDCHP_ADDR_STATUS = 2'h0;
  localparam logic [1:0] FDCHP_ADDR_TRACK = 2'h1;
  localparam logic [1:0] FDCHP_ADDR_SECTOR = 2'h2;
  localparam logic [1:0] FDCHP_ADDR_DATA = 2'h3;
  localparam logic [7:0] FDCHP_RESET_VALUE = 8'h00;
  // ****************************************
  // Status bit positions
  // ****************************************
  localparam int FDCHP_ST_BUSY = 0;
  localparam int FDCHP_ST_REQ = 1;
  localparam int FDCHP_ST_LOST = 2;
  localparam int FDCHP_ST_CRC = 3;
  localparam int FDCHP_ST_NOTFOUND = 4;
  localparam int FDCHP_ST_B5 = 5;
  localparam int FDCHP_ST_B6 = 6;
  localparam int FDCHP_ST_NOTRDY = 7;
  // ****************************************
  // Command decode (upper bits of command_word)
  // ****************************************
  localparam logic [3:0] FDCHP_CMD_FORCE = 4'hd;
  localparam logic [3:0] FDCHP_CMD_RDADDR = 4'hc;
  localparam logic [3:0] FDCHP_CMD_RDTRACK = 4'he;
  localparam logic [3:0] FDCHP_CMD_WRTRACK = 4'hf;
  localparam logic [2:0] FDCHP_CMD_READ = 3'h4;
  localparam logic [2:0] FDCHP_CMD_WRITE = 3'h5;
  // Force-interrupt condition bits
  localparam int FDCHP_FI_TO_READY = 0;
  localparam int FDCHP_FI_TO_NOTREADY = 1;
  localparam int FDCHP_FI_INDEX = 2;
  localparam int FDCHP_FI_NOW = 3;
  // ****************************************
  // Synchronised pin vector layout
  // ****************************************
  localparam int FDCHP_SYNC_STAGES = 2;
  localparam int FDCHP_PIN_W = 17;
  localparam int FDCHP_P_DATA = 9;
  localparam int FDCHP_P_ADDR = 7;
  localparam int FDCHP_P_CS_N = 6;
  localparam int FDCHP_P_RD_N = 5;
  localparam int FDCHP_P_WR_N = 4;
  localparam int FDCHP_P_INDEX_N = 3;
  localparam int FDCHP_P_TR0_N = 2;
  localparam int FDCHP_P_WP_N = 1;
  localparam int FDCHP_P_HLT = 0;
  // Ready and master reset travel in the same vector, above the rest
  localparam int FDCHP_PIN_W_ALL = 19;
  localparam int FDCHP_P_READY = 17;
  localparam int FDCHP_P_MR = 18;
  // ****************************************
  // Host access states
  // ****************************************
  typedef enum logic [2:0] {
    FDCHP_ACC_IDLE = 3'b001,
    FDCHP_ACC_READ = 3'b010,
    FDCHP_ACC_WRITE = 3'b100
  } fdchp_acc_t;
endpackage

// ### logic/fdchp_pin_if.sv
`timescale 1ns/1ps
`default_nettype none
interface fdchp_pin_if #(
  parameter int WIDTH = 19
);
  logic [WIDTH-1:0] raw;
  logic [WIDTH-1:0] sync;
  modport src (output raw, input sync);
  modport syncer (input raw, output sync);
endinterface
`default_nettype wire

// ### logic/fdchp_sync.sv
`timescale 1ns/1ps
`default_nettype none
module fdchp_sync
  import fdchp_pkg::*;
#(
  parameter int WIDTH = FDCHP_PIN_W_ALL
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Pins in, settled copy out
  fdchp_pin_if.syncer pins
);
  // ****************************************
  // Two-stage synchroniser
  // ****************************************
  // Stage one feeds stage two only, so metastability never reaches logic
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  // Refused at elaboration, since the stage count is fixed in the logic below
  if (WIDTH < 1 || FDCHP_SYNC_STAGES != 2) begin : g_bad_cfg
    $error("fdchp_sync: unsupported width or stage count");
  end

  always_comb begin
    meta_d = pins.raw;
    sync_d = meta_q;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= '1;
      sync_q <= '1;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign pins.sync = sync_q;
endmodule // fdchp_sync
`default_nettype wire

// ### logic/fdchp_host_port.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Status bit 0 is one exactly while a command is executing.
// - Type I: status bit 1 is the inverted index pulse input.
// - Type II/III: status bit 1 copies byte_request.
// - Type I: status bit 2 is the inverted track-zero input.
// - Type II/III: status bit 2 flags late byte service; cleared on next update.
// - Status bit 3 flags ID CRC errors; cleared on next status update.
// - Status bit 4 flags track, or track and sector, not found.
// - Type I: status bit 5 is head_load AND head_load_timing.
// - Read: status bits 5 and 6 carry the record-type code.
// - Write and Write Track: status bit 5 reports write fault.
// - Type I: status bit 6 is the inverted write-protect input.
// - Status bit 7 is not-ready OR master reset; II/III refused when not ready.
// - Data lines driven only on chip select with read strobe; written with write strobe.
// - Address 0 status/command, 1 track, 2 sector, 3 data register.
// - Disk read: byte_request rises on new byte, clears on data read.
// - Disk read overwrite of unread byte sets lost data; read continues.
// - Disk write: byte_request rises on shift load, clears on data write.
// - Disk write underrun sends a zero byte and sets lost data.
// - Interrupt on lost data, completion, termination and force-interrupt conditions.
// - Interrupt holds until status read, command write or master reset.
// - Force interrupt with no conditions ends the command quietly.
// - Record-type pairs 00,01,10,11 map to marks FB,FA,F9,F8.
module fdchp_host_port
  import fdchp_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Host bus pins
  input wire logic chip_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [1:0] host_addr,
  input wire logic [7:0] host_data_lines_in,
  output logic [7:0] host_data_lines_out,
  output logic host_data_lines_oe,
  output logic byte_request,
  output logic irq_out,
  // Drive pins
  input wire logic index_pulse_n,
  input wire logic track_zero_n,
  input wire logic write_protect_n,
  input wire logic head_load_timing,
  input wire logic drive_ready,
  input wire logic master_reset,
  // Disk engine, same clock
  input wire logic head_load,
  input wire logic eng_done,
  input wire logic eng_abort,
  input wire logic eng_crc_err,
  input wire logic eng_not_found,
  input wire logic eng_write_fault,
  input wire logic [1:0] eng_record_type,
  input wire logic eng_rd_valid,
  input wire logic [7:0] eng_rd_byte,
  input wire logic eng_wr_take,
  output logic cmd_start,
  output logic cmd_stop,
  output logic [7:0] cmd_word,
  output logic [7:0] track_word,
  output logic [7:0] sector_word,
  output logic [7:0] wr_byte
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  fdchp_pin_if #(.WIDTH(FDCHP_PIN_W_ALL)) pins ();

  assign pins.raw = {master_reset, drive_ready, host_data_lines_in, host_addr,
                     chip_select_n, read_strobe_n, write_strobe_n, index_pulse_n,
                     track_zero_n, write_protect_n, head_load_timing};

  fdchp_sync #(.WIDTH(FDCHP_PIN_W_ALL)) u_sync (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .pins(pins)
  );

  logic [7:0] s_data;
  logic [1:0] s_addr;
  logic s_cs_n;
  logic s_rd_n;
  logic s_wr_n;
  logic s_index_n;
  logic s_tr0_n;
  logic s_wp_n;
  logic s_hlt;
  logic s_ready;
  logic s_mr;

  assign s_data = pins.sync[FDCHP_P_DATA +: 8];
  assign s_addr = pins.sync[FDCHP_P_ADDR +: 2];
  assign s_cs_n = pins.sync[FDCHP_P_CS_N];
  assign s_rd_n = pins.sync[FDCHP_P_RD_N];
  assign s_wr_n = pins.sync[FDCHP_P_WR_N];
  assign s_index_n = pins.sync[FDCHP_P_INDEX_N];
  assign s_tr0_n = pins.sync[FDCHP_P_TR0_N];
  assign s_wp_n = pins.sync[FDCHP_P_WP_N];
  assign s_hlt = pins.sync[FDCHP_P_HLT];
  assign s_ready = pins.sync[FDCHP_P_READY];
  assign s_mr = pins.sync[FDCHP_P_MR];

  // ****************************************
  // Host access tracking
  // ****************************************
  // Side effects fire when the strobe ends, so the host has sampled the data first
  fdchp_acc_t acc_q;
  fdchp_acc_t acc_d;
  logic [1:0] acc_addr_q;
  logic [1:0] acc_addr_d;
  logic [7:0] acc_data_q;
  logic [7:0] acc_data_d;
  logic rd_end;
  logic wr_end;

  always_comb begin
    acc_d = acc_q;
    acc_addr_d = acc_addr_q;
    acc_data_d = acc_data_q;
    rd_end = 1'b0;
    wr_end = 1'b0;
    case (acc_q)
      FDCHP_ACC_IDLE: begin
        if (!s_cs_n && !s_rd_n) begin
          acc_d = FDCHP_ACC_READ;
          acc_addr_d = s_addr;
        end else if (!s_cs_n && !s_wr_n) begin
          acc_d = FDCHP_ACC_WRITE;
          acc_addr_d = s_addr;
        end
      end
      FDCHP_ACC_READ: begin
        if (s_cs_n || s_rd_n) begin
          acc_d = FDCHP_ACC_IDLE;
          rd_end = 1'b1;
        end
      end
      FDCHP_ACC_WRITE: begin
        acc_data_d = s_data;
        if (s_cs_n || s_wr_n) begin
          acc_d = FDCHP_ACC_IDLE;
          wr_end = 1'b1;
        end
      end
      default: begin
        acc_d = FDCHP_ACC_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_q <= FDCHP_ACC_IDLE;
      acc_addr_q <= 2'h0;
      acc_data_q <= FDCHP_RESET_VALUE;
    end else begin
      acc_q <= acc_d;
      acc_addr_q <= acc_addr_d;
      acc_data_q <= acc_data_d;
    end
  end

  // ****************************************
  // Registers, status and interrupt
  // ****************************************
  logic [7:0] command_word_q, command_word_d;
  logic [7:0] track_number_q, track_number_d;
  logic [7:0] sector_number_q, sector_number_d;
  logic [7:0] byte_buffer_q, byte_buffer_d;
  logic [7:0] wr_byte_q, wr_byte_d;
  logic [7:0] rdata_q, rdata_d;
  logic [3:0] fi_arm_q, fi_arm_d;
  logic [1:0] rtype_q, rtype_d;
  logic busy_q, busy_d;
  logic req_q, req_d;
  logic lost_q, lost_d;
  logic crc_q, crc_d;
  logic nf_q, nf_d;
  logic wf_q, wf_d;
  logic irq_q, irq_d;
  logic start_q, start_d;
  logic stop_q, stop_d;
  logic ready_q, index_n_q;
  logic type1, is_read, is_write;
  logic [7:0] status_word;
  logic cmd_wr;
  logic [3:0] new_hi;
  logic irq_set;

  always_comb begin
    type1 = !command_word_q[7];
    is_read = command_word_q[7:5] == FDCHP_CMD_READ;
    is_write = command_word_q[7:5] == FDCHP_CMD_WRITE ||
               command_word_q[7:4] == FDCHP_CMD_WRTRACK;
    status_word = 8'h00;
    status_word[FDCHP_ST_BUSY] = busy_q;
    status_word[FDCHP_ST_REQ] = type1 ? !s_index_n : req_q;
    status_word[FDCHP_ST_LOST] = type1 ? !s_tr0_n : lost_q;
    status_word[FDCHP_ST_CRC] = crc_q;
    status_word[FDCHP_ST_NOTFOUND] = nf_q;
    if (type1) begin
      status_word[FDCHP_ST_B5] = head_load && s_hlt;
      status_word[FDCHP_ST_B6] = !s_wp_n;
    end else if (is_read) begin
      // Code 0..3 stands for marks FB, FA, F9, F8 in that order
      status_word[FDCHP_ST_B5] = rtype_q[0];
      status_word[FDCHP_ST_B6] = rtype_q[1];
    end else if (is_write) begin
      status_word[FDCHP_ST_B5] = wf_q;
      status_word[FDCHP_ST_B6] = !s_wp_n;
    end
    status_word[FDCHP_ST_NOTRDY] = !s_ready || s_mr;
  end

  always_comb begin
    command_word_d = command_word_q;
    track_number_d = track_number_q;
    sector_number_d = sector_number_q;
    byte_buffer_d = byte_buffer_q;
    wr_byte_d = wr_byte_q;
    fi_arm_d = fi_arm_q;
    rtype_d = rtype_q;
    busy_d = busy_q;
    req_d = req_q;
    lost_d = lost_q;
    crc_d = crc_q;
    nf_d = nf_q;
    wf_d = wf_q;
    irq_d = irq_q;
    start_d = 1'b0;
    stop_d = 1'b0;
    irq_set = 1'b0;
    cmd_wr = wr_end && acc_addr_q == FDCHP_ADDR_STATUS;
    new_hi = acc_data_q[7:4];
    // Clears from the host come first so a same-cycle event below wins
    if (rd_end && acc_addr_q == FDCHP_ADDR_STATUS) begin
      irq_d = 1'b0;
    end
    if (rd_end && acc_addr_q == FDCHP_ADDR_DATA && !is_write) begin
      req_d = 1'b0;
    end
    if (wr_end) begin
      case (acc_addr_q)
        FDCHP_ADDR_TRACK: track_number_d = acc_data_q;
        FDCHP_ADDR_SECTOR: sector_number_d = acc_data_q;
        FDCHP_ADDR_DATA: begin
          byte_buffer_d = acc_data_q;
          if (is_write) begin
            req_d = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    if (cmd_wr) begin
      irq_d = 1'b0;
      if (new_hi == FDCHP_CMD_FORCE) begin
        // Conditions stay armed until the next command is written or master reset
        fi_arm_d = acc_data_q[3:0];
        if (busy_q) begin
          busy_d = 1'b0;
          stop_d = 1'b1;
        end
        if (acc_data_q[FDCHP_FI_NOW]) begin
          irq_set = 1'b1;
        end
      end else if (!busy_q) begin
        // A new command is the status update that clears the error flags
        command_word_d = acc_data_q;
        fi_arm_d = 4'h0;
        lost_d = 1'b0;
        crc_d = 1'b0;
        nf_d = 1'b0;
        wf_d = 1'b0;
        rtype_d = 2'h0;
        req_d = acc_data_q[7:4] == FDCHP_CMD_WRTRACK && s_ready && !s_mr;
        if (acc_data_q[7] && (!s_ready || s_mr)) begin
          irq_set = 1'b1;
        end else begin
          busy_d = 1'b1;
          start_d = 1'b1;
        end
      end
    end
    if (busy_q && eng_rd_valid) begin
      byte_buffer_d = eng_rd_byte;
      req_d = 1'b1;
      if (req_q && !(rd_end && acc_addr_q == FDCHP_ADDR_DATA)) begin
        lost_d = 1'b1;
      end
    end
    if (busy_q && eng_wr_take) begin
      req_d = 1'b1;
      if (req_q && !(wr_end && acc_addr_q == FDCHP_ADDR_DATA)) begin
        wr_byte_d = 8'h00;
        lost_d = 1'b1;
      end else begin
        wr_byte_d = byte_buffer_d;
      end
    end
    if (busy_q && eng_crc_err) begin
      crc_d = 1'b1;
    end
    if (busy_q && eng_not_found) begin
      nf_d = 1'b1;
    end
    if (busy_q && eng_write_fault) begin
      wf_d = 1'b1;
    end
    if (busy_q && is_read && eng_rd_valid) begin
      rtype_d = eng_record_type;
    end
    if (lost_d && !lost_q) begin
      irq_set = 1'b1;
    end
    if (busy_q && (eng_done || eng_abort)) begin
      busy_d = 1'b0;
      irq_set = 1'b1;
    end
    if (fi_arm_q[FDCHP_FI_TO_READY] && s_ready && !ready_q) begin
      irq_set = 1'b1;
    end
    if (fi_arm_q[FDCHP_FI_TO_NOTREADY] && !s_ready && ready_q) begin
      irq_set = 1'b1;
    end
    if (fi_arm_q[FDCHP_FI_INDEX] && !s_index_n && index_n_q) begin
      irq_set = 1'b1;
    end
    if (irq_set) begin
      irq_d = 1'b1;
    end
    // Master reset parks the controller idle; not-ready shows it meanwhile
    if (s_mr) begin
      busy_d = 1'b0;
      req_d = 1'b0;
      irq_d = 1'b0;
      fi_arm_d = 4'h0;
      stop_d = busy_q;
      start_d = 1'b0;
    end
    case (acc_d == FDCHP_ACC_READ ? s_addr : acc_addr_q)
      FDCHP_ADDR_STATUS: rdata_d = status_word;
      FDCHP_ADDR_TRACK: rdata_d = track_number_q;
      FDCHP_ADDR_SECTOR: rdata_d = sector_number_q;
      default: rdata_d = byte_buffer_q;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      command_word_q <= FDCHP_RESET_VALUE;
      track_number_q <= FDCHP_RESET_VALUE;
      sector_number_q <= FDCHP_RESET_VALUE;
      byte_buffer_q <= FDCHP_RESET_VALUE;
      wr_byte_q <= FDCHP_RESET_VALUE;
      rdata_q <= FDCHP_RESET_VALUE;
      fi_arm_q <= 4'h0;
      rtype_q <= 2'h0;
      busy_q <= 1'b0;
      req_q <= 1'b0;
      lost_q <= 1'b0;
      crc_q <= 1'b0;
      nf_q <= 1'b0;
      wf_q <= 1'b0;
      irq_q <= 1'b0;
      start_q <= 1'b0;
      stop_q <= 1'b0;
      ready_q <= 1'b1;
      index_n_q <= 1'b1;
    end else begin
      command_word_q <= command_word_d;
      track_number_q <= track_number_d;
      sector_number_q <= sector_number_d;
      byte_buffer_q <= byte_buffer_d;
      wr_byte_q <= wr_byte_d;
      rdata_q <= rdata_d;
      fi_arm_q <= fi_arm_d;
      rtype_q <= rtype_d;
      busy_q <= busy_d;
      req_q <= req_d;
      lost_q <= lost_d;
      crc_q <= crc_d;
      nf_q <= nf_d;
      wf_q <= wf_d;
      irq_q <= irq_d;
      start_q <= start_d;
      stop_q <= stop_d;
      ready_q <= s_ready;
      index_n_q <= s_index_n;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign host_data_lines_out = rdata_q;
  assign host_data_lines_oe = acc_q == FDCHP_ACC_READ;
  assign byte_request = req_q;
  assign irq_out = irq_q;
  assign cmd_start = start_q;
  assign cmd_stop = stop_q;
  assign cmd_word = command_word_q;
  assign track_word = track_number_q;
  assign sector_word = sector_number_q;
  assign wr_byte = wr_byte_q;
endmodule // fdchp_host_port
`default_nettype wire

// ### dv/fdchp_host_port_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Port checks
// ****************************************
module fdchp_host_port_chk (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Host bus
  input wire logic chip_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic host_data_lines_oe,
  input wire logic byte_request,
  input wire logic irq_out,
  input wire logic master_reset,
  // Engine side
  input wire logic eng_done,
  input wire logic eng_rd_valid,
  input wire logic eng_wr_take,
  input wire logic cmd_start,
  input wire logic [7:0] wr_byte
);
  logic rd_sel;
  assign rd_sel = !chip_select_n && !read_strobe_n;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // Margins of several cycles cover the two-stage pin synchroniser
  property p_idle_bus;
    chip_select_n [*6] |-> !host_data_lines_oe;
  endproperty
  a_idle_bus: assert property (p_idle_bus)
    else $error("data lines driven while not selected");
  property p_oe_cause;
    $rose(host_data_lines_oe) |-> $past(rd_sel, 2) || $past(rd_sel, 3) || $past(rd_sel, 4);
  endproperty
  a_oe_cause: assert property (p_oe_cause)
    else $error("data lines driven without a read");
  property p_wr_quiet;
    (read_strobe_n && !write_strobe_n) [*6] |-> !host_data_lines_oe;
  endproperty
  a_wr_quiet: assert property (p_wr_quiet)
    else $error("data lines driven during a write");
  property p_rd_req;
    eng_rd_valid |=> byte_request;
  endproperty
  a_rd_req: assert property (p_rd_req)
    else $error("no request after disk byte");
  property p_wr_req;
    eng_wr_take |=> byte_request;
  endproperty
  a_wr_req: assert property (p_wr_req)
    else $error("no request after shift load");
  property p_underrun;
    eng_wr_take && byte_request |=> wr_byte == 8'h00;
  endproperty
  a_underrun: assert property (p_underrun)
    else $error("underrun byte not zero");
  property p_irq_hold;
    (irq_out && chip_select_n && !master_reset) [*5] |=> irq_out;
  endproperty
  a_irq_hold: assert property (p_irq_hold)
    else $error("interrupt dropped without host access");
  property p_start_src;
    cmd_start |-> !$past(write_strobe_n, 2) || !$past(write_strobe_n, 3) ||
      !$past(write_strobe_n, 4) || !$past(write_strobe_n, 5);
  endproperty
  a_start_src: assert property (p_start_src)
    else $error("command started without a write");
  property p_done_irq;
    eng_done |-> ##[1:3] irq_out;
  endproperty
  a_done_irq: assert property (p_done_irq)
    else $error("no interrupt on completion");
  property p_mr;
    master_reset [*6] |-> !byte_request && !irq_out;
  endproperty
  a_mr: assert property (p_mr)
    else $error("master reset left request or interrupt");
endmodule // fdchp_host_port_chk
bind fdchp_host_port fdchp_host_port_chk u_chk (
  .sys_clk, .rst_b, .chip_select_n, .read_strobe_n, .write_strobe_n, .host_data_lines_oe,
  .byte_request, .irq_out, .master_reset, .eng_done, .eng_rd_valid, .eng_wr_take,
  .cmd_start, .wr_byte
);
`default_nettype wire

// ### dv/fdchp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Host processor on the register bus
// ****************************************
module fdchp_host_model (
  // Clock
  input wire logic sys_clk,
  // Bus pins
  output var logic chip_select_n,
  output var logic read_strobe_n,
  output var logic write_strobe_n,
  output var logic [1:0] host_addr,
  output var logic [7:0] host_data_lines_in,
  input wire logic [7:0] host_data_lines_out,
  input wire logic host_data_lines_oe
);
  initial begin
    chip_select_n = 1'b1;
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    host_addr = 2'h0;
    host_data_lines_in = 8'h00;
  end
  // Strobe held past the synchroniser, then a gap so the end is seen
  task automatic acc(input logic wr, input logic sel, input logic [1:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge sys_clk);
    #1;
    host_addr = a;
    host_data_lines_in = d;
    chip_select_n = !sel;
    read_strobe_n = wr;
    write_strobe_n = !wr;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (n < 4 || (!wr && sel && host_data_lines_oe !== 1'b1 && n < 12));
    q = host_data_lines_out;
    chip_select_n = 1'b1;
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    // Released lines must not keep the written value
    host_data_lines_in = ~d;
    repeat (5) @(posedge sys_clk);
    #1;
  endtask
endmodule // fdchp_host_model
`default_nettype wire

// ### dv/fdchp_host_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Self-checking bench
// ****************************************
module fdchp_host_port_tb;
  import fdchp_pkg::*;
  logic sys_clk, rst_b, chip_select_n, read_strobe_n, write_strobe_n;
  logic [1:0] host_addr, eng_record_type, rt;
  logic [7:0] host_data_lines_in, host_data_lines_out, eng_rd_byte, cmd_word, track_word;
  logic [7:0] sector_word, wr_byte, q;
  logic host_data_lines_oe, byte_request, irq_out, index_pulse_n, track_zero_n;
  logic write_protect_n, head_load_timing, drive_ready, master_reset, head_load, eng_done;
  logic eng_abort, eng_crc_err, eng_not_found, eng_write_fault, eng_rd_valid, eng_wr_take;
  logic cmd_start, cmd_stop;
  logic [31:0] seed = 32'h06e90266;
  logic [31:0] v;
  logic [7:0] mreg [4];
  logic [7:0] rq [$];
  int err_total = 0;
  int cmp_count = 0;
  int starts = 0;
  int stops = 0;
  int busy, typ, req, lost, crcf, nff, wff;
  fdchp_host_port uut (.*);
  fdchp_host_model host (.*);
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [7:0] est();
    logic [7:0] s;
    s = 8'h00;
    s[0] = busy[0];
    s[7] = ~drive_ready | master_reset;
    if (typ == 1) begin
      s[1] = ~index_pulse_n;
      s[2] = ~track_zero_n;
      s[5] = head_load & head_load_timing;
      s[6] = ~write_protect_n;
    end else begin
      s[1] = req[0];
      s[2] = lost[0];
      s[3] = crcf[0];
      s[4] = nff[0];
      s[5] = (typ == 2) ? rt[0] : wff[0];
      s[6] = (typ == 2) ? rt[1] : ~write_protect_n;
    end
    return s;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Start and stop are one-cycle pulses, so they are counted rather than compared
  always @(negedge sys_clk) begin
    if (cmd_start === 1'b1) starts++;
    if (cmd_stop === 1'b1) stops++;
  end
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    host.acc(1'b0, 1'b1, a, 8'h00, d);
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    logic [7:0] x;
    host.acc(1'b1, 1'b1, a, d, x);
  endtask
  task automatic cmd(input logic [7:0] c, input int t);
    wr(2'h0, c);
    typ = t;
    busy = 1;
    req = (c[7:4] == FDCHP_CMD_WRTRACK) ? 1 : 0;
    {lost, crcf, nff, wff} = '0;
  endtask
  // One-cycle engine pulses: done, crc, not found, fault, byte in, byte out
  task automatic eng(input logic [5:0] s);
    @(posedge sys_clk);
    #1;
    {eng_done, eng_crc_err, eng_not_found, eng_write_fault, eng_rd_valid, eng_wr_take} = s;
    @(posedge sys_clk);
    #1;
    {eng_done, eng_crc_err, eng_not_found, eng_write_fault, eng_rd_valid, eng_wr_take} = '0;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial begin
    #100000;
    err_total++;
    complete_run();
  end
  initial begin
    rst_b = 1'b0;
    {index_pulse_n, track_zero_n, write_protect_n, drive_ready} = 4'hf;
    {head_load_timing, master_reset, head_load, eng_abort} = 4'h0;
    {eng_done, eng_crc_err, eng_not_found, eng_write_fault, eng_rd_valid, eng_wr_take} = '0;
    eng_rd_byte = 8'h00;
    eng_record_type = 2'h0;
    repeat (3) @(posedge sys_clk);
    #1;
    rst_b = 1'b1;
    chk({5'h0, irq_out, byte_request, host_data_lines_oe}, 8'h00);
    repeat (3) @(posedge sys_clk);
    #1;
    for (int i = 1; i < 3; i++) begin
      v = rnd();
      wr(2'(i), v[7:0]);
      mreg[i] = v[7:0];
      host.acc(1'b1, 1'b0, 2'(i), ~v[7:0], q);
      rd(2'(i), q);
      chk(q, mreg[i]);
    end
    chk(track_word, mreg[1]);
    chk(sector_word, mreg[2]);
    cmd(8'h00, 1);
    repeat (4) begin
      v = rnd();
      {index_pulse_n, track_zero_n, write_protect_n, head_load_timing} = v[3:0];
      {head_load, drive_ready} = v[5:4];
      rd(2'h0, q);
      chk(q, est());
    end
    {index_pulse_n, track_zero_n, write_protect_n, drive_ready} = 4'hf;
    eng(6'h20);
    busy = 0;
    chk({7'h0, irq_out}, 8'h01);
    rd(2'h0, q);
    chk(q, est());
    chk({7'h0, irq_out}, 8'h00);
    cmd(8'h80, 2);
    for (int k = 0; k < 3; k++) begin
      v = rnd();
      eng_rd_byte = v[7:0];
      eng_record_type = v[9:8];
      eng(6'h02);
      rt = v[9:8];
      lost = lost | req;
      if (req != 0) void'(rq.pop_front());
      rq.push_back(v[7:0]);
      req = 1;
      chk({6'h0, irq_out, byte_request}, {6'h0, lost[0], 1'b1});
      rd(2'h0, q);
      chk(q, est());
      if (k != 1) begin
        rd(2'h3, q);
        chk(q, rq.pop_front());
        req = 0;
        chk({7'h0, byte_request}, 8'h00);
      end
    end
    eng(6'h18);
    {crcf, nff} = {32'd1, 32'd1};
    eng(6'h20);
    busy = 0;
    rd(2'h0, q);
    chk(q, est());
    cmd(8'ha0, 3);
    rd(2'h0, q);
    chk(q, est());
    v = rnd();
    wr(2'h3, v[7:0]);
    eng(6'h01);
    req = 1;
    chk(wr_byte, v[7:0]);
    eng(6'h01);
    lost = 1;
    chk(wr_byte, 8'h00);
    eng(6'h04);
    wff = 1;
    rd(2'h0, q);
    chk(q, est());
    wr(2'h3, ~v[7:0]);
    chk({7'h0, byte_request}, 8'h00);
    eng_abort = 1'b1;
    @(posedge sys_clk);
    #1;
    eng_abort = 1'b0;
    chk({7'h0, irq_out}, 8'h01);
    cmd(8'hf0, 3);
    chk({7'h0, byte_request}, 8'h01);
    wr(2'h0, 8'hd0);
    chk(cmd_word, 8'hf0);
    rd(2'h0, q);
    chk({6'h0, irq_out, q[0]}, 8'h00);
    wr(2'h0, 8'hd8);
    chk({7'h0, irq_out}, 8'h01);
    host.acc(1'b1, 1'b0, 2'h0, 8'h00, q);
    chk({7'h0, irq_out}, 8'h01);
    rd(2'h0, q);
    chk({7'h0, irq_out}, 8'h00);
    drive_ready = 1'b0;
    wr(2'h0, 8'h80);
    chk({7'h0, irq_out}, 8'h01);
    rd(2'h0, q);
    chk(q & 8'h81, 8'h80);
    drive_ready = 1'b1;
    master_reset = 1'b1;
    rd(2'h0, q);
    chk(q & 8'h81, 8'h80);
    master_reset = 1'b0;
    chk(8'(starts), 8'h04);
    chk(8'(stops), 8'h01);
    complete_run();
  end
endmodule // fdchp_host_port_tb
`default_nettype wire
